// *** acm_defs.svh ***
// Constants of the conversion mode and output coding block
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ACM_RES_W 18
`define ACM_RES_MSB 17
`define ACM_FIFO_DEPTH 16
`define ACM_LVL_W 5
`define ACM_ADDR_W 4
`define ACM_DATA_W 32
`define ACM_STAT_W 14
`define ACM_CTRL_W 2

// ----------------------------------------------------------------
// Register offsets, fields and reset values
// ----------------------------------------------------------------
`define ACM_OFF_CTRL 4'h0
`define ACM_OFF_STAT 4'h4
`define ACM_OFF_DATA 4'h8
`define ACM_CTRL_EN_BIT 0
`define ACM_CTRL_FLUSH_BIT 1
`define ACM_CTRL_RST 2'h1
`define ACM_BIT_THREE 3

`endif

// *** acm_pkg.sv ***
// Types of the conversion mode and output coding block
package acm_pkg;

   // Interface width selected by the two strap pins
   typedef enum logic [1:0]
   {
      ACM_IF_PAR18 = 2'b00,
      ACM_IF_PAR16 = 2'b01,
      ACM_IF_BYTE = 2'b10,
      ACM_IF_SERIAL = 2'b11
   } acm_iface_t;

   // Conversion mode
   typedef enum logic [1:0]
   {
      ACM_CONV_NORMAL = 2'b00,
      ACM_CONV_FAST = 2'b01,
      ACM_CONV_REDUCED = 2'b10
   } acm_conv_t;

   // Pin straps as sampled, one bundle through the synchroniser
   typedef struct packed
   {
      logic [1:0] iface;
      logic fast;
      logic low_power;
      logic coding;
      logic form_lo;
      logic form_hi;
   } acm_strap_t;

   // Status word as read by software
   typedef struct packed
   {
      logic [4:0] level;
      logic full;
      logic empty;
      logic [1:0] word_form;
      logic twos;
      logic [1:0] conv;
      logic [1:0] iface;
   } acm_status_t;

endpackage

// *** acm_fifo.sv ***
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
module acm_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic en_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // Handshakes, full and empty from the occupancy count
   assign in_ready_o = (count_q != FULL_CNT);
   assign out_valid_o = (count_q != '0);
   assign push = en_i && in_valid_i && in_ready_o && !flush_i;
   assign pop = en_i && out_valid_o && out_ready_i && !flush_i;
   assign out_data_o = mem_q[rd_ptr_q];
   assign level_o = count_q;

   // Storage, no reset needed
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // Pointers and count
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else if (en_i)
      begin
         if (flush_i)
         begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
         end
         else
         begin
            if (push)
            begin
               wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
               rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop)
            begin
               count_q <= count_q + 1'b1;
            end
            else if (pop && !push)
            begin
               count_q <= count_q - 1'b1;
            end
         end
      end
   end

endmodule

// *** acm_conv_ctrl.sv ***
// Conversion mode, output coding and low data pin control
//
// Summary of operation
// - Two strap bits pick 18-bit, 16-bit, byte-wide or serial output port.
// - In 18-bit mode lowest pin drives result bit 0; coding is straight binary.
// - Other modes: lowest pin is coding input; low inverts MSB for twos complement.
// - Fast input high, low-power low: fast mode, highest throughput.
// - Both mode inputs low: normal mode, accuracy independent of conversion interval.
// - Low-power high, fast low: reduced-power mode, power scales with rate.
// - Second-lowest pin is result bit in 18-bit mode, word-form input in 16/byte.
// - Bit-three pin carries result bit 3 in parallel modes and is always output.
`timescale 1ns/1ps
`include "acm_defs.svh"
module acm_conv_ctrl
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [1:0] iface_sel_pin_i,
   input wire logic fast_conv_pin_i,
   input wire logic low_power_pin_i,
   input wire logic bit0_or_coding_select_i,
   output logic bit0_or_coding_select_o,
   output logic bit0_or_coding_select_oe_o,
   input wire logic bit1_or_word_form_sel_lo_i,
   output logic bit1_or_word_form_sel_lo_o,
   output logic bit1_or_word_form_sel_lo_oe_o,
   input wire logic bit2_or_word_form_sel_hi_i,
   output logic bit2_or_word_form_sel_hi_o,
   output logic bit2_or_word_form_sel_hi_oe_o,
   output logic result_bit_three_o,
   output logic result_bit_three_oe_o,
   input wire logic res_valid_i,
   input wire logic [`ACM_RES_MSB:0] res_data_i,
   output logic res_ready_o,
   output logic [`ACM_RES_MSB:0] par_word_o,
   output logic [1:0] word_form_o,
   output logic [1:0] conv_mode_o,
   input wire logic [`ACM_ADDR_W-1:0] reg_addr_i,
   input wire logic [`ACM_DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [`ACM_DATA_W-1:0] reg_rdata_o
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // True for the three parallel widths
   function automatic logic is_parallel(input acm_pkg::acm_iface_t sel);
      is_parallel = (sel != acm_pkg::ACM_IF_SERIAL);
   endfunction

   // True where the low pins act as inputs of the parallel port
   function automatic logic is_narrow(input acm_pkg::acm_iface_t sel);
      is_narrow = is_parallel(sel) && (sel != acm_pkg::ACM_IF_PAR18);
   endfunction

   // Invert the MSB for twos complement outside 18-bit mode
   function automatic logic [`ACM_RES_MSB:0] apply_coding(input logic [`ACM_RES_MSB:0] word,
                                                           input acm_pkg::acm_iface_t sel,
                                                           input logic coding);
      apply_coding = word;
      if (sel != acm_pkg::ACM_IF_PAR18 && !coding)
      begin
         apply_coding[`ACM_RES_MSB] = !word[`ACM_RES_MSB];
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   acm_pkg::acm_strap_t strap_raw;
   acm_pkg::acm_strap_t strap_s1_q;
   acm_pkg::acm_strap_t strap_s2_q;
   acm_pkg::acm_iface_t iface_q;
   acm_pkg::acm_conv_t conv_mode_q;
   acm_pkg::acm_status_t status;
   logic [`ACM_CTRL_W-1:0] ctrl_q;
   logic flush_q;
   logic [1:0] word_form_q;
   logic [`ACM_RES_MSB:0] par_word_q;
   logic [`ACM_DATA_W-1:0] rdata_q;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [`ACM_RES_MSB:0] fifo_out_data;
   logic [`ACM_RES_MSB:0] coded_word;
   logic [`ACM_LVL_W-1:0] fifo_level;
   logic capture_en;
   logic pop_req;
   logic [2:0] low_oe;
   logic [2:0] low_out;

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------

   // Bundle of asynchronous pin levels
   assign strap_raw = '{iface: iface_sel_pin_i, fast: fast_conv_pin_i, low_power: low_power_pin_i,
                        coding: bit0_or_coding_select_i, form_lo: bit1_or_word_form_sel_lo_i,
                        form_hi: bit2_or_word_form_sel_hi_i};

   // Two flops; only the second stage is read
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         strap_s1_q <= '0;
         strap_s2_q <= '0;
      end
      else if (clk_en_i)
      begin
         strap_s1_q <= strap_raw;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Interface width from the synchronised straps
   assign iface_q = acm_pkg::acm_iface_t'(strap_s2_q.iface);

   // ----------------------------------------------------------------
   // Conversion mode
   // ----------------------------------------------------------------

   // Mode from fast and low-power straps, clash falls back to normal
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         conv_mode_q <= acm_pkg::ACM_CONV_NORMAL;
      end
      else if (clk_en_i)
      begin
         unique case ({strap_s2_q.fast, strap_s2_q.low_power})
            2'b10: conv_mode_q <= acm_pkg::ACM_CONV_FAST;
            2'b00: conv_mode_q <= acm_pkg::ACM_CONV_NORMAL;
            2'b01: conv_mode_q <= acm_pkg::ACM_CONV_REDUCED;
            2'b11: conv_mode_q <= acm_pkg::ACM_CONV_NORMAL;
         endcase
      end
   end

   assign conv_mode_o = conv_mode_q;

   // ----------------------------------------------------------------
   // Word form selection
   // ----------------------------------------------------------------

   // Sampled only while the low pins are inputs of a narrow bus
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         word_form_q <= '0;
      end
      else if (clk_en_i)
      begin
         word_form_q <= is_narrow(iface_q) ? {strap_s2_q.form_hi, strap_s2_q.form_lo} : 2'h0;
      end
   end

   assign word_form_o = word_form_q;

   // ----------------------------------------------------------------
   // Result buffering
   // ----------------------------------------------------------------

   // Capture gate and pop on a read of the data register
   assign capture_en = ctrl_q[`ACM_CTRL_EN_BIT];
   assign res_ready_o = capture_en && fifo_in_ready;
   assign pop_req = reg_rd_i && (reg_addr_i == `ACM_OFF_DATA);

   acm_fifo
   #(
      .WIDTH(`ACM_RES_W),
      .DEPTH(`ACM_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .en_i(clk_en_i),
      .flush_i(flush_q),
      .in_valid_i(res_valid_i && capture_en),
      .in_ready_o(fifo_in_ready),
      .in_data_i(res_data_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop_req),
      .out_data_o(fifo_out_data),
      .level_o(fifo_level)
   );

   // Coding chosen at the moment the word leaves the FIFO
   assign coded_word = apply_coding(fifo_out_data, iface_q, strap_s2_q.coding);

   // Word presented on the parallel bus, held until the next pop
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         par_word_q <= '0;
      end
      else if (clk_en_i && pop_req && fifo_out_valid && !flush_q)
      begin
         par_word_q <= coded_word;
      end
   end

   assign par_word_o = par_word_q;

   // ----------------------------------------------------------------
   // Low data pins
   // ----------------------------------------------------------------

   // The three lowest pins drive result bits only in 18-bit mode
   generate
      for (genvar k = 0; k < 3; k++)
      begin : g_low_pin
         assign low_oe[k] = (iface_q == acm_pkg::ACM_IF_PAR18);
         assign low_out[k] = low_oe[k] & par_word_q[k];
      end
   endgenerate

   assign bit0_or_coding_select_o = low_out[0];
   assign bit0_or_coding_select_oe_o = low_oe[0];
   assign bit1_or_word_form_sel_lo_o = low_out[1];
   assign bit1_or_word_form_sel_lo_oe_o = low_oe[1];
   assign bit2_or_word_form_sel_hi_o = low_out[2];
   assign bit2_or_word_form_sel_hi_oe_o = low_oe[2];

   // Bit three always driven, data only on a parallel bus
   assign result_bit_three_oe_o = 1'b1;
   assign result_bit_three_o = is_parallel(iface_q) & par_word_q[`ACM_BIT_THREE];

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------

   // Control register: capture enable and a self-clearing flush
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_q <= `ACM_CTRL_RST;
         flush_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         flush_q <= reg_wr_i && (reg_addr_i == `ACM_OFF_CTRL) && reg_wdata_i[`ACM_CTRL_FLUSH_BIT];
         if (reg_wr_i && reg_addr_i == `ACM_OFF_CTRL)
         begin
            ctrl_q[`ACM_CTRL_EN_BIT] <= reg_wdata_i[`ACM_CTRL_EN_BIT];
         end
      end
   end

   // Status word
   assign status = '{level: fifo_level, full: !fifo_in_ready, empty: !fifo_out_valid,
                     word_form: word_form_q, twos: (iface_q != acm_pkg::ACM_IF_PAR18) && !strap_s2_q.coding,
                     conv: conv_mode_q, iface: iface_q};

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdata_q <= '0;
      end
      else if (clk_en_i)
      begin
         rdata_q <= '0;
         if (reg_rd_i)
         begin
            unique case (reg_addr_i)
               `ACM_OFF_CTRL: rdata_q <= {{(`ACM_DATA_W - `ACM_CTRL_W){1'b0}}, ctrl_q};
               `ACM_OFF_STAT: rdata_q <= {{(`ACM_DATA_W - `ACM_STAT_W){1'b0}}, status};
               `ACM_OFF_DATA: rdata_q <= fifo_out_valid ? {{(`ACM_DATA_W - `ACM_RES_W){1'b0}}, coded_word} : '0;
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign reg_rdata_o = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   // Strap bits reach the mode decode two enabled edges later
   a_iface_sync_delay: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      $past(clk_en_i) && $past(clk_en_i, 2) |-> strap_s2_q.iface == $past(iface_sel_pin_i, 2))
      else $error("interface select not tracking its pins");

   // 18-bit mode pops the stored word unchanged
   a_bin_pop_word: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && pop_req && fifo_out_valid && !flush_q && iface_q == acm_pkg::ACM_IF_PAR18
      |=> par_word_q == $past(fifo_out_data))
      else $error("18-bit mode word not straight binary");

   // Low coding input inverts only the MSB
   a_twos_msb_flip: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && pop_req && fifo_out_valid && !flush_q && is_narrow(iface_q) && !strap_s2_q.coding
      |=> par_word_q == {!$past(fifo_out_data[`ACM_RES_MSB]), $past(fifo_out_data[`ACM_RES_MSB-1:0])})
      else $error("twos complement coding wrong");

   // Lowest pin released outside 18-bit mode
   a_coding_pin_input: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      iface_q != acm_pkg::ACM_IF_PAR18 |-> !bit0_or_coding_select_oe_o && !bit0_or_coding_select_o)
      else $error("coding pin driven outside 18-bit mode");

   // Fast strap held two edges gives fast mode
   a_fast_mode_entry: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (clk_en_i && strap_s2_q.fast && !strap_s2_q.low_power) [*2] |=> conv_mode_o == acm_pkg::ACM_CONV_FAST)
      else $error("fast mode not entered");

   // Both straps low gives normal mode
   a_normal_mode: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && !strap_s2_q.fast && !strap_s2_q.low_power |=> conv_mode_q == acm_pkg::ACM_CONV_NORMAL)
      else $error("normal mode not selected");

   // Low-power strap gives reduced-power mode
   a_reduced_mode: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && !strap_s2_q.fast && strap_s2_q.low_power |=> conv_mode_q == acm_pkg::ACM_CONV_REDUCED)
      else $error("reduced-power mode not selected");

   // Clashing straps never give fast or reduced mode
   a_clash_fallback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && strap_s2_q.fast && strap_s2_q.low_power |=> conv_mode_q == acm_pkg::ACM_CONV_NORMAL)
      else $error("clashing straps not mapped to normal");

   // Word-form pins are inputs on 16-bit and byte buses
   a_word_form_pins: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && is_narrow(iface_q) |-> !bit1_or_word_form_sel_lo_oe_o && !bit2_or_word_form_sel_hi_oe_o
      ##1 word_form_o == $past({strap_s2_q.form_hi, strap_s2_q.form_lo}))
      else $error("word form pins misused");

   // Bit three always driven, with the held word on a parallel bus
   a_bit_three_out: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      result_bit_three_oe_o && (!is_parallel(iface_q) || result_bit_three_o == par_word_q[`ACM_BIT_THREE]))
      else $error("bit three pin wrong");

   // Full buffer stalls the converter core
   a_fifo_backpressure: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      fifo_level == `ACM_LVL_W'(`ACM_FIFO_DEPTH) |-> !res_ready_o)
      else $error("ready while buffer full");

   // Status read answers in the next cycle only
   a_status_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_en_i && reg_rd_i && reg_addr_i == `ACM_OFF_STAT |=> reg_rdata_o[1:0] == $past(iface_q)
      ##1 (!$past(clk_en_i) || $past(reg_rd_i) || reg_rdata_o == '0))
      else $error("status read timing wrong");

   c_fast_mode: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      conv_mode_q == acm_pkg::ACM_CONV_FAST);
   c_twos_pop: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      pop_req && fifo_out_valid && is_narrow(iface_q) && !strap_s2_q.coding);
   c_fifo_full: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      res_valid_i && !fifo_in_ready);
   c_serial_sel: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      iface_q == acm_pkg::ACM_IF_SERIAL);

endmodule

// *** acm_host_model.sv ***
// Host side model: strap drivers and resolution of the shared low data pins
`timescale 1ns/1ps
module acm_host_model
(
   input wire logic clk_i,
   input wire logic [1:0] iface_i,
   input wire logic fast_i,
   input wire logic low_power_i,
   input wire logic coding_i,
   input wire logic [1:0] form_i,
   input wire logic [2:0] dev_o_i,
   input wire logic [2:0] dev_oe_i,
   output logic [1:0] iface_sel_pin_o,
   output logic fast_conv_pin_o,
   output logic low_power_pin_o,
   output logic [2:0] pin_lvl_o
);
   logic wiggle_q = 1'h0;
   logic [2:0] host_drv;
   logic [2:0] host_val;

   // Changing pattern so an undriven pin never looks stable
   always_ff @(posedge clk_i)
   begin
      wiggle_q <= ~wiggle_q;
   end

   // Straps pass straight through; both mode straps high only when commanded
   assign iface_sel_pin_o = iface_i;
   assign fast_conv_pin_o = fast_i;
   assign low_power_pin_o = low_power_i;

   // Host releases the low pins in the 18-bit port, straps pin 0 otherwise and pins 1 and 2 only on the 16-bit and byte ports
   assign host_drv[0] = (iface_i != 2'h0);
   assign host_drv[1] = (iface_i == 2'h1) || (iface_i == 2'h2);
   assign host_drv[2] = host_drv[1];
   assign host_val = {form_i[1], form_i[0], coding_i};

   // Wire level from both parties' enables
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         pin_lvl_o[i] = dev_oe_i[i] ? dev_o_i[i] : (host_drv[i] ? host_val[i] : wiggle_q);
      end
   end
endmodule

// *** adc_conversion_mode_and_output_coding_tb.sv ***
// Self-checking testbench of the conversion mode and output coding block
`timescale 1ns/1ps
`include "acm_defs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module adc_conversion_mode_and_output_coding_tb;
   logic clk_sys_i = 1'h0;
   logic reset_n_i = 1'h0;
   logic clk_en = 1'h1;
   logic res_valid = 1'h0;
   logic [17:0] res_data = 18'h00000;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [1:0] h_iface = 2'h0;
   logic h_fast = 1'h0;
   logic h_lp = 1'h0;
   logic h_coding = 1'h1;
   logic [1:0] h_form = 2'h0;
   logic [1:0] iface_pin;
   logic fast_pin;
   logic lp_pin;
   logic [2:0] pin_lvl;
   logic [2:0] dev_o;
   logic [2:0] dev_oe;
   logic bit3;
   logic bit3_oe;
   logic res_ready;
   logic [17:0] par_word;
   logic [1:0] word_form;
   logic [1:0] conv_mode;
   logic [31:0] rdata;
   logic [31:0] rd_q;
   logic [1:0] exp_mode [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
   int num_errors = 0;
   int comparisons = 0;

   // ----------------------------------------------------------------
   // Clock, design and host model
   // ----------------------------------------------------------------
   initial
   begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   acm_conv_ctrl DUT
   (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
      .iface_sel_pin_i(iface_pin), .fast_conv_pin_i(fast_pin), .low_power_pin_i(lp_pin),
      .bit0_or_coding_select_i(pin_lvl[0]), .bit0_or_coding_select_o(dev_o[0]),
      .bit0_or_coding_select_oe_o(dev_oe[0]),
      .bit1_or_word_form_sel_lo_i(pin_lvl[1]), .bit1_or_word_form_sel_lo_o(dev_o[1]),
      .bit1_or_word_form_sel_lo_oe_o(dev_oe[1]),
      .bit2_or_word_form_sel_hi_i(pin_lvl[2]), .bit2_or_word_form_sel_hi_o(dev_o[2]),
      .bit2_or_word_form_sel_hi_oe_o(dev_oe[2]),
      .result_bit_three_o(bit3), .result_bit_three_oe_o(bit3_oe),
      .res_valid_i(res_valid), .res_data_i(res_data), .res_ready_o(res_ready),
      .par_word_o(par_word), .word_form_o(word_form), .conv_mode_o(conv_mode),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(rdata)
   );

   acm_host_model host
   (
      .clk_i(clk_sys_i), .iface_i(h_iface), .fast_i(h_fast), .low_power_i(h_lp),
      .coding_i(h_coding), .form_i(h_form), .dev_o_i(dev_o), .dev_oe_i(dev_oe),
      .iface_sel_pin_o(iface_pin), .fast_conv_pin_o(fast_pin), .low_power_pin_o(lp_pin),
      .pin_lvl_o(pin_lvl)
   );

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic reg_write(input logic [3:0] addr, input logic [31:0] data);
      @(posedge clk_sys_i);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'h1;
      @(posedge clk_sys_i);
      reg_wr <= 1'h0;
      #1;
   endtask

   task automatic reg_read(input logic [3:0] addr, output logic [31:0] data);
      @(posedge clk_sys_i);
      reg_addr <= addr;
      reg_rd <= 1'h1;
      @(posedge clk_sys_i);
      reg_rd <= 1'h0;
      #1;
      data = rdata;
   endtask

   task automatic push(input logic [17:0] w);
      @(posedge clk_sys_i);
      res_valid <= 1'h1;
      res_data <= w;
      #1;
      // Word held until the core side is ready
      while (!res_ready)
      begin
         @(posedge clk_sys_i);
         #1;
      end
      @(posedge clk_sys_i);
      res_valid <= 1'h0;
      #1;
   endtask

   // Sets the straps and lets them pass the synchroniser
   task automatic straps(input logic [1:0] ifc, input logic f, input logic lp, input logic cod,
                         input logic [1:0] frm);
      @(posedge clk_sys_i);
      h_iface <= ifc;
      h_fast <= f;
      h_lp <= lp;
      h_coding <= cod;
      h_form <= frm;
      repeat (5) @(posedge clk_sys_i);
      #1;
   endtask

   // Pops one word and checks the coded result on every output
   task automatic pop_check(input logic [17:0] w, input logic twos);
      logic [17:0] exp_w;
      exp_w = twos ? (w ^ 18'h20000) : w;
      reg_read(`ACM_OFF_DATA, rd_q);
      `CHK(rd_q, {14'h0000, exp_w})
      `CHK(par_word, exp_w)
      `CHK(bit3, (h_iface == 2'h3) ? 1'h0 : exp_w[3])
      `CHK(bit3_oe, 1'h1)
      if (h_iface == 2'h0)
      begin
         `CHK(pin_lvl, exp_w[2:0])
      end
   endtask

   task automatic test_done;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog and tests
   // ----------------------------------------------------------------
   initial
   begin
      #(40 * 4000);
      num_errors++;
      test_done();
   end

   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1'h1;
      // 18-bit port: pins driven as result bits, coding pin ignored
      straps(2'h0, 1'h0, 1'h0, 1'h0, 2'h3);
      `CHK(dev_oe, 3'h7)
      push(18'h2A5A5);
      push(18'h1000A);
      pop_check(18'h2A5A5, 1'h0);
      pop_check(18'h1000A, 1'h0);
      // Other ports with both coding levels
      for (int m = 1; m < 4; m++)
      begin
         for (int c = 0; c < 2; c++)
         begin
            straps(m[1:0], 1'h0, 1'h0, c[0], m[1:0]);
            `CHK(dev_oe, 3'h0)
            `CHK(word_form, (m == 3) ? 2'h0 : m[1:0])
            push(18'h2A5AD);
            pop_check(18'h2A5AD, ~c[0]);
            reg_read(`ACM_OFF_STAT, rd_q);
            `CHK(rd_q[4:0], {~c[0], 2'h0, m[1:0]})
         end
      end
      // Mode straps, both high included
      for (int k = 0; k < 4; k++)
      begin
         straps(2'h1, k[1], k[0], 1'h1, 2'h0);
         `CHK(conv_mode, exp_mode[k])
         reg_read(`ACM_OFF_STAT, rd_q);
         `CHK(rd_q[3:2], exp_mode[k])
         push(18'h0F0F3);
         pop_check(18'h0F0F3, 1'h0);
      end
      // Fill the buffer until it refuses, then drain it
      for (int i = 0; i < 16; i++)
         push(18'h00100 + i[17:0]);
      `CHK(res_ready, 1'h0)
      reg_read(`ACM_OFF_STAT, rd_q);
      `CHK(rd_q[13:7], 7'h42)
      for (int i = 0; i < 16; i++)
         pop_check(18'h00100 + i[17:0], 1'h0);
      reg_read(`ACM_OFF_DATA, rd_q);
      `CHK(rd_q, 32'h00000000)
      // Unmapped place, capture disable and flush
      reg_write(4'hC, 32'hFFFFFFFF);
      reg_read(4'hC, rd_q);
      `CHK(rd_q, 32'h00000000)
      reg_read(`ACM_OFF_CTRL, rd_q);
      `CHK(rd_q, 32'h00000001)
      reg_write(`ACM_OFF_CTRL, 32'h00000000);
      `CHK(res_ready, 1'h0)
      reg_write(`ACM_OFF_CTRL, 32'h00000001);
      push(18'h3FFFF);
      push(18'h00001);
      reg_write(`ACM_OFF_CTRL, 32'h00000003);
      reg_read(`ACM_OFF_STAT, rd_q);
      `CHK(rd_q[13:7], 7'h01)
      // Strobes while frozen are lost
      @(posedge clk_sys_i);
      clk_en <= 1'h0;
      reg_write(`ACM_OFF_CTRL, 32'h00000000);
      @(posedge clk_sys_i);
      clk_en <= 1'h1;
      reg_read(`ACM_OFF_CTRL, rd_q);
      `CHK(rd_q, 32'h00000001)
      test_done();
   end
endmodule
